// file: ithc_target.sv
// Overview of operation
// [R1] answer 7-bit target address, default 0x41
// [R2] work at 100k, 400k and 1M bit rates
// [R3] pointer increments after each data byte
// [R4] pointer survives stop and bus release
// [R5] address-less read starts at last+1
// [R6] host write: S, addr+0, pointer, data, P
// [R7] drive ack or nack on ninth clock
// [R8] host read: pointer write, Sr, addr+1
// [R9] host nacks last read byte, then stop
// [R10] target address changeable; enable one at time
// [R11] tolerate i3c traffic, legacy i2c only
// [R12] running app reads 0xC0 or 0x80
// [R13] app request write, then poll running app
// [R14] cpu reset bit 7 pulses, self clears
// [R15] cpu not ready: only 0xE0 up usable
// [R16] pon 0 to 1 starts oscillator, interrupts
// [R17] cpu decides reset or idle on interrupt
// [R18] pon written 0 raises standby interrupt
// [R19] pointer wraps from 0xFF to 0x00
// [R20] first write byte loads the pointer
module ithc_target (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // i2c pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // target address change
    input wire logic i_target_addr_we,
    input wire logic [6:0] i_target_addr,
    // cpu side
    input wire logic i_cpu_ready,
    input wire ithc_pkg::ithc_wr_type i_cpu_wr,
    input wire logic i_osc_stop,
    output ithc_pkg::ithc_event_type o_event,
    output logic o_osc_enable,
    output logic [7:0] o_requested_app_code
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ithc_pkg::ithc_state_type state_reg, state_next;
    ithc_pkg::ithc_wr_type host_wr;
    ithc_pkg::ithc_event_type event_next;
    logic scl_flt, sda_flt, scl_prev_reg, sda_prev_reg;
    logic scl_rise, scl_fall, start_cond, stop_cond, byte_end;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg, tx_reg, ptr_reg, mem_rdata, rd_value;
    logic [7:0] ctrl_value;
    logic [6:0] target_addr_reg;
    logic rw_reg, first_reg, ack_reg, host_ack_reg, pon_reg, sda_oe_next;
    logic addr_match, locked, wr_data_done, wr_ptr_done, rd_ack_rise;
    logic ctrl_wr, in_rx_byte;

    // ------------------------------------------------------------
    // pin conditioning and bus conditions
    // ------------------------------------------------------------
    ithc_pin_filter u_scl_filter (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_scl),
        .o_level(scl_flt)
    );

    ithc_pin_filter u_sda_filter (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_sda),
        .o_level(sda_flt)
    );

    // previous filtered levels for edge finding
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_flt;
            sda_prev_reg <= sda_flt;
        end
    end

    // edges, start/stop and byte boundaries
    assign scl_rise = scl_flt & ~scl_prev_reg; // R2
    assign scl_fall = ~scl_flt & scl_prev_reg;
    assign start_cond = scl_flt & scl_prev_reg & sda_prev_reg & ~sda_flt;
    assign stop_cond = scl_flt & scl_prev_reg & ~sda_prev_reg & sda_flt;
    assign byte_end = scl_fall & (bit_cnt_reg == ithc_pkg::BYTE_BITS);
    assign in_rx_byte = (state_reg == ithc_pkg::ST_ADDR) |
                        (state_reg == ithc_pkg::ST_WR_BYTE);
    assign addr_match = (shift_reg[7:1] == target_addr_reg); // R1
    assign locked = ~i_cpu_ready & (ptr_reg < ithc_pkg::CPU_FREE_BASE);
    assign wr_ptr_done = byte_end & (state_reg == ithc_pkg::ST_WR_BYTE) &
                         first_reg;
    assign wr_data_done = byte_end & (state_reg == ithc_pkg::ST_WR_BYTE) &
                          ~first_reg;
    assign rd_ack_rise = scl_rise & (state_reg == ithc_pkg::ST_RD_ACK);
    assign ctrl_wr = wr_data_done &
                     (ptr_reg == ithc_pkg::OFS_POWER_CPU_CTRL);

    // ------------------------------------------------------------
    // transfer state machine
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (stop_cond) begin
            state_next = ithc_pkg::ST_IDLE;
        end else if (start_cond) begin
            state_next = ithc_pkg::ST_ADDR;
        end else begin
            case (state_reg)
                ithc_pkg::ST_ADDR: begin
                    if (byte_end) begin
                        // foreign or i3c headers are left alone
                        state_next = addr_match ? ithc_pkg::ST_ADDR_ACK
                                                : ithc_pkg::ST_WAIT_STOP; // R11
                    end
                end
                ithc_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        state_next = rw_reg ? ithc_pkg::ST_RD_BYTE
                                            : ithc_pkg::ST_WR_BYTE; // R8
                    end
                end
                ithc_pkg::ST_WR_BYTE: begin
                    if (byte_end) begin
                        state_next = ithc_pkg::ST_WR_ACK;
                    end
                end
                ithc_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        state_next = ithc_pkg::ST_WR_BYTE;
                    end
                end
                ithc_pkg::ST_RD_BYTE: begin
                    if (byte_end) begin
                        state_next = ithc_pkg::ST_RD_ACK;
                    end
                end
                ithc_pkg::ST_RD_ACK: begin
                    if (scl_fall) begin
                        state_next = host_ack_reg ? ithc_pkg::ST_RD_BYTE
                                                  : ithc_pkg::ST_WAIT_STOP; // R9
                    end
                end
                ithc_pkg::ST_IDLE: state_next = ithc_pkg::ST_IDLE;
                ithc_pkg::ST_WAIT_STOP: state_next = ithc_pkg::ST_WAIT_STOP;
                default: state_next = ithc_pkg::ST_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ithc_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // bit counter restarts with every state change or start
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_cnt_reg <= ithc_pkg::BIT_CNT_ZERO;
        end else if (start_cond || (state_next != state_reg)) begin
            bit_cnt_reg <= ithc_pkg::BIT_CNT_ZERO;
        end else if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + ithc_pkg::BIT_CNT_STEP;
        end
    end

    // receive shifter, direction and first-byte flags
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_reg <= ithc_pkg::BYTE_ZERO;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
        end else begin
            if (scl_rise && in_rx_byte) begin
                shift_reg <= {shift_reg[6:0], sda_flt};
            end
            if (byte_end && (state_reg == ithc_pkg::ST_ADDR)) begin
                rw_reg <= shift_reg[0];
                first_reg <= 1'b1;
            end else if (wr_ptr_done) begin
                first_reg <= 1'b0; // R20
            end
        end
    end

    // ack decision for written bytes and host ack capture
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
            host_ack_reg <= 1'b0;
        end else begin
            if (wr_ptr_done) begin
                ack_reg <= 1'b1;
            end else if (wr_data_done) begin
                ack_reg <= ~locked; // R7 R15
            end
            if (rd_ack_rise) begin
                host_ack_reg <= ~sda_flt; // R9
            end
        end
    end

    // ------------------------------------------------------------
    // register pointer
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ptr_reg <= ithc_pkg::PTR_RESET;
        end else if (wr_ptr_done) begin // R4
            ptr_reg <= shift_reg; // R20
        end else if (wr_data_done || rd_ack_rise) begin
            ptr_reg <= ptr_reg + ithc_pkg::PTR_STEP; // R3 R19
        end
    end

    // ------------------------------------------------------------
    // register space
    // ------------------------------------------------------------
    assign host_wr.we = wr_data_done & ~locked &
                        (ptr_reg < ithc_pkg::CPU_FREE_BASE); // R15
    assign host_wr.addr = ptr_reg;
    assign host_wr.data = shift_reg;

    ithc_reg_mem u_reg_mem (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_host_wr(host_wr),
        .i_cpu_wr(i_cpu_wr),
        .i_rd_addr(ptr_reg),
        .o_rd_data(mem_rdata)
    );

    // control readback: reset bit reads zero, ready from the cpu
    always_comb begin
        ctrl_value = ithc_pkg::BYTE_ZERO;
        ctrl_value[ithc_pkg::CTRL_CPU_READY_BIT] = i_cpu_ready; // R15
        ctrl_value[ithc_pkg::CTRL_PON_BIT] = pon_reg;
    end

    // read source; running app code lives at offset 0 of the cpu space
    always_comb begin
        if (locked) begin
            rd_value = ithc_pkg::BYTE_ZERO; // R15
        end else if (ptr_reg < ithc_pkg::CPU_FREE_BASE) begin
            rd_value = mem_rdata; // R12
        end else if (ptr_reg == ithc_pkg::OFS_POWER_CPU_CTRL) begin
            rd_value = ctrl_value;
        end else begin
            rd_value = ithc_pkg::BYTE_ZERO;
        end
    end

    // transmit shifter loads on entry to a read byte
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_reg <= ithc_pkg::BYTE_ZERO;
        end else if (scl_fall && (state_next == ithc_pkg::ST_RD_BYTE) &&
                     (state_reg != ithc_pkg::ST_RD_BYTE)) begin
            tx_reg <= rd_value; // R5
        end else if (scl_fall && (state_reg == ithc_pkg::ST_RD_BYTE)) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // open-drain data drive
    // ------------------------------------------------------------
    always_comb begin
        case (state_reg)
            ithc_pkg::ST_ADDR_ACK: sda_oe_next = 1'b1; // R1
            ithc_pkg::ST_WR_ACK: sda_oe_next = ack_reg; // R7
            ithc_pkg::ST_RD_BYTE: sda_oe_next = ~tx_reg[7];
            default: sda_oe_next = 1'b0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sda_oe <= 1'b0;
        end else begin
            o_sda_oe <= sda_oe_next;
        end
    end

    assign o_sda_out = 1'b0;

    // ------------------------------------------------------------
    // target address and power/cpu control
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            target_addr_reg <= ithc_pkg::TARGET_ADDR_DEFAULT; // R1
        end else if (i_target_addr_we) begin
            target_addr_reg <= i_target_addr; // R10
        end
    end

    // pon bit and oscillator; start beats a same-cycle stop
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pon_reg <= ithc_pkg::PON_RESET;
            o_osc_enable <= ithc_pkg::PON_RESET;
        end else begin
            if (ctrl_wr) begin
                pon_reg <= shift_reg[ithc_pkg::CTRL_PON_BIT];
            end
            if (ctrl_wr && shift_reg[ithc_pkg::CTRL_PON_BIT] && !pon_reg) begin
                o_osc_enable <= 1'b1; // R16
            end else if (i_osc_stop) begin
                o_osc_enable <= 1'b0; // R18
            end
        end
    end

    // one-cycle events towards the cpu
    always_comb begin
        event_next.cpu_reset = ctrl_wr &
                               shift_reg[ithc_pkg::CTRL_CPU_RESET_BIT]; // R14
        event_next.power_on_core_interrupt = ctrl_wr & ~pon_reg &
            shift_reg[ithc_pkg::CTRL_PON_BIT]; // R16 R17
        event_next.standby_interrupt = ctrl_wr &
            ~shift_reg[ithc_pkg::CTRL_PON_BIT]; // R18
        event_next.app_request = host_wr.we &
            (ptr_reg == ithc_pkg::OFS_APP_REQUEST); // R13
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_event <= '0;
            o_requested_app_code <= ithc_pkg::BYTE_ZERO;
        end else begin
            o_event <= event_next;
            if (event_next.app_request) begin
                o_requested_app_code <= shift_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_ptr_data_step: assert property (wr_data_done || rd_ack_rise |=> // R3
        ptr_reg == 8'($past(ptr_reg) + ithc_pkg::PTR_STEP))
        else $error("pointer did not step after a data byte");
    chk_ptr_wraps: assert property ((ptr_reg == 8'hFF) && // R19
        (wr_data_done || rd_ack_rise) |=> ptr_reg == 8'h00)
        else $error("pointer did not wrap to zero");
    chk_ptr_load: assert property (wr_ptr_done |=> // R20
        (ptr_reg == $past(shift_reg)) && !first_reg)
        else $error("first write byte not loaded into pointer");
    chk_ptr_keep_stop: assert property (stop_cond |=> // R4
        $stable(ptr_reg) [*3])
        else $error("pointer changed across a stop");
    chk_addr_ack: assert property (byte_end && state_reg == // R1
        ithc_pkg::ST_ADDR && addr_match |=> ##1 o_sda_oe)
        else $error("matching address not acknowledged");
    chk_foreign_quiet: assert property ((state_reg == // R11
        ithc_pkg::ST_WAIT_STOP) |=> !o_sda_oe)
        else $error("drove the bus for a foreign address");
    chk_target_change: assert property (i_target_addr_we |=> // R10
        target_addr_reg == $past(i_target_addr))
        else $error("target address not updated");
    chk_cpu_reset_pulse: assert property (ctrl_wr && // R14
        shift_reg[ithc_pkg::CTRL_CPU_RESET_BIT] |=>
        o_event.cpu_reset ##1 !o_event.cpu_reset)
        else $error("cpu reset not a single pulse");
    chk_locked_write: assert property (host_wr.we |-> // R15
        i_cpu_ready || (ptr_reg >= ithc_pkg::CPU_FREE_BASE))
        else $error("cpu space written while cpu not ready");
    chk_pon_start: assert property (ctrl_wr && !pon_reg && // R16
        shift_reg[ithc_pkg::CTRL_PON_BIT] |=>
        o_osc_enable && o_event.power_on_core_interrupt && pon_reg)
        else $error("oscillator start missing");
    chk_standby_irq: assert property (ctrl_wr && // R18
        !shift_reg[ithc_pkg::CTRL_PON_BIT] |=>
        o_event.standby_interrupt && !pon_reg)
        else $error("standby interrupt missing");
    chk_app_request: assert property (event_next.app_request |=> // R13
        o_event.app_request && o_requested_app_code == $past(shift_reg))
        else $error("application request not forwarded");

    cov_write_data: cover property (wr_data_done ##[1:600] stop_cond);
    cov_read_byte: cover property (rd_ack_rise && host_ack_reg);
    cov_read_end_nack: cover property (state_reg == ithc_pkg::ST_RD_ACK
        ##1 state_reg == ithc_pkg::ST_WAIT_STOP);
    cov_pon_start: cover property (o_event.power_on_core_interrupt);

endmodule : ithc_target

// file: ithc_pkg.sv
package ithc_pkg;

    // ----------------------------------------------------------------
    // register map and codes
    // ----------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h41;
    localparam logic [7:0] APP_CODE_MEASURE = 8'hC0;
    localparam logic [7:0] APP_CODE_BOOT = 8'h80;
    localparam logic [7:0] OFS_RUNNING_APP = 8'h00;
    localparam logic [7:0] OFS_APP_MAJOR_REV = 8'h01;
    localparam logic [7:0] OFS_APP_REQUEST = 8'h02;
    localparam logic [7:0] OFS_POWER_CPU_CTRL = 8'hE0;
    // first address that stays usable while the cpu is not ready
    localparam logic [7:0] CPU_FREE_BASE = OFS_POWER_CPU_CTRL;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;

    // power and cpu control fields
    localparam int CTRL_CPU_RESET_BIT = 7;
    localparam int CTRL_CPU_READY_BIT = 6;
    localparam int CTRL_PON_BIT = 0;
    localparam logic PON_RESET = 1'b1;

    // ----------------------------------------------------------------
    // bus framing and timing
    // ----------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_STEP = 4'h1;
    localparam int MEM_DEPTH = 256;
    localparam int CLK_PERIOD_PS = 5000;
    // spikes up to this width are suppressed (mixed i3c traffic)
    localparam int SPIKE_NS = 50;
    localparam int FILTER_CYCLES = (SPIKE_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [3:0] FILTER_COUNT = 4'(FILTER_CYCLES);
    localparam logic [3:0] FILTER_STEP = 4'h1;
    localparam logic [3:0] FILTER_ZERO = 4'h0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR_BYTE = 3'b011,
        ST_WR_ACK = 3'b100,
        ST_RD_BYTE = 3'b101,
        ST_RD_ACK = 3'b110,
        ST_WAIT_STOP = 3'b111
    } ithc_state_type;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } ithc_wr_type;

    typedef struct packed {
        logic cpu_reset;
        logic power_on_core_interrupt;
        logic standby_interrupt;
        logic app_request;
    } ithc_event_type;

endpackage : ithc_pkg

// file: ithc_pin_filter.sv
module ithc_pin_filter (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // raw pin and filtered level
    input wire logic i_pin,
    output logic o_level
);

    logic meta_reg;
    logic sync_reg;
    logic [3:0] stable_cnt_reg;

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= i_pin;
            sync_reg <= meta_reg;
        end
    end

    // level accepted only after it held for the spike window
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stable_cnt_reg <= ithc_pkg::FILTER_ZERO;
            o_level <= 1'b1;
        end else if (sync_reg == o_level) begin
            stable_cnt_reg <= ithc_pkg::FILTER_ZERO;
        end else if (stable_cnt_reg == ithc_pkg::FILTER_COUNT) begin
            stable_cnt_reg <= ithc_pkg::FILTER_ZERO;
            o_level <= sync_reg; // R11
        end else begin
            stable_cnt_reg <= stable_cnt_reg + ithc_pkg::FILTER_STEP;
        end
    end

endmodule : ithc_pin_filter

// file: ithc_reg_mem.sv
module ithc_reg_mem (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // write ports
    input wire ithc_pkg::ithc_wr_type i_host_wr,
    input wire ithc_pkg::ithc_wr_type i_cpu_wr,
    // read port
    input wire logic [7:0] i_rd_addr,
    output logic [7:0] o_rd_data
);

    logic [7:0] mem_reg [ithc_pkg::MEM_DEPTH];

    // ------------------------------------------------------------
    // storage, cpu write wins on the same address
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < ithc_pkg::MEM_DEPTH; i++) begin
                mem_reg[i] <= ithc_pkg::BYTE_ZERO;
            end
        end else begin
            if (i_host_wr.we) begin
                mem_reg[i_host_wr.addr] <= i_host_wr.data;
            end
            if (i_cpu_wr.we) begin
                mem_reg[i_cpu_wr.addr] <= i_cpu_wr.data;
            end
        end
    end

    // registered read data
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= ithc_pkg::BYTE_ZERO;
        end else begin
            o_rd_data <= mem_reg[i_rd_addr];
        end
    end

endmodule : ithc_reg_mem

// file: ithc_host_model.sv
module ithc_host_model (
    // bus pins, sda high means released
    output logic o_scl,
    output logic o_sda,
    input wire logic i_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime Q = 62.5; // quarter of a 250 ns bit
    logic r;

    // idle bus: clock stands high, data released
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // start or repeated start
    task start();
        o_sda = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda = 1'b0;
        #Q o_scl = 1'b0;
    endtask : start

    // stop ends every frame
    task stop();
        o_sda = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda = 1'b1;
        #Q;
    endtask : stop

    // one clock, data set while scl low, sampled mid high
    task bit_xfer(input logic d, output logic q_bit);
        o_sda = d;
        #Q o_scl = 1'b1;
        #Q q_bit = i_sda;
        #Q o_scl = 1'b0;
        #Q;
    endtask : bit_xfer

    // byte out, ack read on ninth clock
    task wr_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    // byte in, host acks or nacks on ninth clock as the caller asks
    task rd_byte(output logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, b[i]);
        end
        bit_xfer(~ack, r);
    endtask : rd_byte
endmodule : ithc_host_model

// file: test_i2c_target_host_control.sv
module test_i2c_target_host_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic scl, sda_host, sda_wire, o_sda_out, o_sda_oe, ack;
    logic i_target_addr_we = 1'b0;
    logic [6:0] i_target_addr = 7'h00;
    logic i_cpu_ready = 1'b0;
    logic i_osc_stop = 1'b0;
    ithc_pkg::ithc_wr_type i_cpu_wr = '0;
    ithc_pkg::ithc_event_type o_event;
    logic o_osc_enable;
    logic [7:0] o_requested_app_code, rd;
    logic [6:0] tgt = ithc_pkg::TARGET_ADDR_DEFAULT;
    logic [7:0] codes [2] = '{8'h80, 8'hC0};
    int error_cnt = 0;
    int cmp_count = 0;
    int ev_cnt [4] = '{0, 0, 0, 0};

    always #2.5 i_core_clk = ~i_core_clk;
    // open drain data line with pull-up
    assign sda_wire = sda_host & ~(o_sda_oe & ~o_sda_out);

    ithc_target i_ithc_target (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_scl(scl), .i_sda(sda_wire), .o_sda_out(o_sda_out),
        .o_sda_oe(o_sda_oe), .i_target_addr_we(i_target_addr_we),
        .i_target_addr(i_target_addr), .i_cpu_ready(i_cpu_ready),
        .i_cpu_wr(i_cpu_wr), .i_osc_stop(i_osc_stop), .o_event(o_event),
        .o_osc_enable(o_osc_enable),
        .o_requested_app_code(o_requested_app_code));
    ithc_host_model i_ithc_host_model (.o_scl(scl), .o_sda(sda_host),
        .i_sda(sda_wire));

    // count event pulses per kind
    always @(posedge i_core_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (o_event[k] === 1'b1) begin
                ev_cnt[k]++;
            end
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // address, pointer and one data byte
    task automatic xfer_wr(input logic [7:0] p, d, input logic ea);
        i_ithc_host_model.start();
        i_ithc_host_model.wr_byte({tgt, 1'b0}, ack);
        chk(8'(ack), 8'h01);
        i_ithc_host_model.wr_byte(p, ack);
        chk(8'(ack), 8'h01);
        i_ithc_host_model.wr_byte(d, ack);
        chk(8'(ack), 8'(ea));
        i_ithc_host_model.stop();
    endtask : xfer_wr

    // read from the current pointer, one byte, nack then stop
    task automatic rd_cur(input logic [7:0] exp);
        i_ithc_host_model.start();
        i_ithc_host_model.wr_byte({tgt, 1'b1}, ack);
        chk(8'(ack), 8'h01);
        i_ithc_host_model.rd_byte(rd, 1'b0);
        i_ithc_host_model.stop();
        chk(rd, exp);
    endtask : rd_cur

    task automatic xfer_rd(input logic [7:0] p, exp);
        i_ithc_host_model.start();
        i_ithc_host_model.wr_byte({tgt, 1'b0}, ack);
        i_ithc_host_model.wr_byte(p, ack);
        chk(8'(ack), 8'h01);
        rd_cur(exp);
    endtask : xfer_rd

    task automatic cpu_write(input logic [7:0] a, d);
        @(posedge i_core_clk);
        #1 i_cpu_wr = '{1'b1, a, d};
        @(posedge i_core_clk);
        #1 i_cpu_wr.we = 1'b0;
    endtask : cpu_write

    task automatic results();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // hang guard
    initial begin
        #400000;
        error_cnt++;
        results();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge i_core_clk);
        #1 i_rst_n = 1'b1;
        repeat (20) @(posedge i_core_clk);
        chk(8'(o_osc_enable), 8'h01);
        #1;
        xfer_rd(8'hE0, 8'h01);
        xfer_wr(8'h02, 8'hC0, 1'b0);
        xfer_rd(8'h00, 8'h00);
        $display("test locked done at %0t", $time);
        @(posedge i_core_clk);
        #1 i_cpu_ready = 1'b1;
        xfer_rd(8'hE0, 8'h41);
        foreach (codes[i]) begin
            xfer_wr(8'h02, codes[i], 1'b1);
            chk(o_requested_app_code, codes[i]);
            cpu_write(8'h00, codes[i]);
            xfer_rd(8'h00, codes[i]);
        end
        chk(8'(ev_cnt[0]), 8'h02);
        xfer_wr(8'h01, 8'h5A, 1'b1);
        rd_cur(8'hC0);
        rd_cur(8'h00);
        xfer_wr(8'hFF, 8'h77, 1'b1);
        rd_cur(8'hC0);
        $display("test pointer done at %0t", $time);
        tgt = 7'h42;
        i_ithc_host_model.start();
        i_ithc_host_model.wr_byte({tgt, 1'b0}, ack);
        i_ithc_host_model.stop();
        chk(8'(ack), 8'h00);
        cpu_write(8'hFF, 8'h00);
        i_target_addr = tgt;
        i_target_addr_we = 1'b1;
        @(posedge i_core_clk);
        #1 i_target_addr_we = 1'b0;
        xfer_rd(8'h01, 8'h5A);
        $display("test address done at %0t", $time);
        xfer_wr(8'hE0, 8'h00, 1'b1);
        chk(8'(ev_cnt[1]), 8'h01);
        xfer_rd(8'hE0, 8'h40);
        @(posedge i_core_clk);
        #1 i_osc_stop = 1'b1;
        @(posedge i_core_clk);
        #1 i_osc_stop = 1'b0;
        repeat (2) @(posedge i_core_clk);
        chk(8'(o_osc_enable), 8'h00);
        xfer_wr(8'hE0, 8'h01, 1'b1);
        chk(8'(o_osc_enable), 8'h01);
        xfer_wr(8'hE0, 8'h81, 1'b1);
        chk(8'(ev_cnt[3]), 8'h01);
        chk(8'(ev_cnt[2]), 8'h01);
        xfer_rd(8'hE0, 8'h41);
        $display("test power done at %0t", $time);
        results();
    end
endmodule : test_i2c_target_host_control
